//--- adc_scan_consts.svh
// constants for the converter scan sequencer
`ifndef ADC_SCAN_CONSTS_SVH
`define ADC_SCAN_CONSTS_SVH
`define ADC_RESULT_BASE_ADDR 5'h01
`define ADC_RESULT_LAST_ADDR 5'h08
`define ADC_CTRL_ADDR        5'h03
`define ADC_CTRL_RESET       8'h00
`define ADC_BIT_RUN          0
`define ADC_BIT_REPEAT       1
`define ADC_BIT_POWER        2
`define ADC_BIT_SCAN         3
`define ADC_BIT_HALVE        4
`define ADC_LAST_LSB         5
`define ADC_LAST_MSB         7
`define ADC_CONV_CYCLES      82
`define ADC_CONV_CYCLES_VAL  7'h52
`define ADC_HALVE_DIV        2
`define ADC_STARTUP_US       60
`define ADC_CLK_MHZ          40
`define ADC_STARTUP_CYCLES   (`ADC_STARTUP_US * `ADC_CLK_MHZ)
`endif

//--- adc_scan_pkg.sv
// types for the converter scan sequencer
package adc_scan_pkg;
  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_WAKE  = 2'b01,
    ST_CONV  = 2'b10,
    ST_NEXT  = 2'b11
  } seq_state_type;
endpackage : adc_scan_pkg

//--- adc_conv_clock.sv
// converter clock enable: master rate or master rate halved
module adc_conv_clock (
  // clock and reset
  input  wire logic i_clk,
  input  wire logic i_reset_n,
  // control
  input  wire logic i_run,
  input  wire logic i_halve,
  // enable out
  output logic      o_tick
);
  logic phase_q;

  always_ff @(posedge i_clk) begin
    if (!i_reset_n || !i_run) begin
      phase_q <= 1'b0;
    end else begin
      phase_q <= ~phase_q;
    end
  end

  // divided by two: one tick every other master cycle
  assign o_tick = i_run & (i_halve ? phase_q : 1'b1);
endmodule : adc_conv_clock

//--- adc_scan_sequencer.sv
// converter scan sequencer with control and result registers
// How it works
// - each conversion stores 8-bit result per channel
// - input at or above top gives FFh
// - input below bottom gives 00h
// - wait state leaves conversions running
// - halt disables converter until start-up delay
// - one channel single: convert, flag, idle
// - scan single: channels 0..last, one flag
// - one channel repeat overwrites its result
// - scan repeat cycles channels 0..last forever
// - repeat modes stop when run cleared
// - run bit one starts, zero stops
// - hardware clears run after single sequence
// - last channel field bits 7..5, ascending scan
// - last channel zero converts channel 0
// - clock halve bit divides converter clock
// - power bit enables, reset zero, halt forces
// - result reloaded when its conversion completes
// - end of conversion drives interrupt request
// - one conversion takes 82 converter clocks
// - halved converter clock is master over two
`include "adc_scan_consts.svh"
module adc_scan_sequencer
  import adc_scan_pkg::*;
#(
  parameter int STARTUP_CYCLES = `ADC_STARTUP_CYCLES
) (
  // clock and reset
  input  wire logic       I_CLK_SYS,
  input  wire logic       I_RESET_N,
  // core power states
  input  wire logic       I_HALT,
  input  wire logic       I_WAIT,
  // control register write port
  input  wire logic       I_CFG_WE,
  input  wire logic [4:0] I_CFG_ADDR,
  input  wire logic [7:0] I_CFG_WDATA,
  output logic      [7:0] O_CFG_RDATA,
  // result register read port
  input  wire logic [4:0] I_RES_ADDR,
  output logic      [7:0] O_RES_RDATA,
  // analog front end
  input  wire logic [7:0] I_SAR_CODE,
  input  wire logic       I_ABOVE_TOP,
  input  wire logic       I_BELOW_BOTTOM,
  output logic      [2:0] O_MUX_SEL,
  output logic            O_SAMPLE,
  output logic            O_BIAS_EN,
  // interrupt request
  output logic            O_EOC_IRQ
);
  logic [7:0]    ctrl_q;
  logic [7:0]    result_q [0:7];
  logic [7:0]    rdata_q;
  logic [7:0]    res_rdata_q;
  logic [2:0]    chan_q;
  logic [6:0]    cnt_q;
  logic [11:0]   wake_q;
  logic          eoc_q;
  logic          done_pulse;
  logic          tick;
  logic          halt_q;
  logic          conv_end;
  logic          wake_done;
  logic [7:0]    conv_cyc_q;
  logic          seq_last;
  logic [7:0]    sample;
  seq_state_type state_q;

  wire run     = ctrl_q[`ADC_BIT_RUN];
  wire repeat_ = ctrl_q[`ADC_BIT_REPEAT];
  wire power   = ctrl_q[`ADC_BIT_POWER];
  wire scan    = ctrl_q[`ADC_BIT_SCAN];
  wire halve   = ctrl_q[`ADC_BIT_HALVE];
  wire [2:0] last_ch = ctrl_q[`ADC_LAST_MSB:`ADC_LAST_LSB];
  wire ctrl_wr = I_CFG_WE && (I_CFG_ADDR == `ADC_CTRL_ADDR);
  // wait mode is not looked at: only halt gates the converter
  wire active  = power && !I_HALT;

  function automatic logic [7:0] saturate(input logic [7:0] code,
                                          input logic top, input logic bot);
    if (top) begin
      saturate = 8'hFF;
    end else if (bot) begin
      saturate = 8'h00;
    end else begin
      saturate = code;
    end
  endfunction : saturate

  function automatic logic res_hit(input logic [4:0] a);
    res_hit = (a >= `ADC_RESULT_BASE_ADDR) && (a <= `ADC_RESULT_LAST_ADDR);
  endfunction : res_hit

  adc_conv_clock u_clk (
    .i_clk     (I_CLK_SYS),
    .i_reset_n (I_RESET_N),
    .i_run     (state_q == ST_CONV),
    .i_halve   (halve),
    .o_tick    (tick)
  );

  // a stop landing on the last tick must not leave a result or a flag behind
  assign conv_end  = (state_q == ST_CONV) && active && run && tick &&
                     (cnt_q == `ADC_CONV_CYCLES_VAL - 7'h01);
  assign wake_done = (state_q == ST_WAKE) && active && run &&
                     (wake_q == 12'(STARTUP_CYCLES - 1));
  assign seq_last = !scan || (chan_q == last_ch);
  assign sample   = saturate(I_SAR_CODE, I_ABOVE_TOP, I_BELOW_BOTTOM);
  assign done_pulse = conv_end && seq_last;

  always_ff @(posedge I_CLK_SYS) begin
    if (!I_RESET_N) begin
      halt_q <= 1'b0;
    end else if (I_HALT) begin
      // held until the wake delay has run, however late the next start comes
      halt_q <= 1'b1;
    end else if (wake_done) begin
      halt_q <= 1'b0;
    end
  end

  // control register
  always_ff @(posedge I_CLK_SYS) begin
    if (!I_RESET_N) begin
      ctrl_q <= `ADC_CTRL_RESET;
    end else begin
      if (ctrl_wr) begin
        ctrl_q <= I_CFG_WDATA;
      end
      if (done_pulse && !repeat_ && !(ctrl_wr && I_CFG_WDATA[`ADC_BIT_RUN])) begin
        ctrl_q[`ADC_BIT_RUN] <= 1'b0;
      end
      if (I_HALT) begin
        ctrl_q[`ADC_BIT_POWER] <= 1'b0;
      end
    end
  end

  // sequencer
  always_ff @(posedge I_CLK_SYS) begin
    if (!I_RESET_N) begin
      state_q <= ST_IDLE;
      chan_q  <= 3'h0;
      cnt_q   <= 7'h00;
      wake_q  <= 12'h000;
    end else if (!active || !run) begin
      // stopping abandons the conversion in flight
      state_q <= ST_IDLE;
      cnt_q   <= 7'h00;
      if (!power) begin
        wake_q <= 12'h000;
      end
    end else begin
      case (state_q)
        ST_IDLE: begin
          chan_q  <= scan ? 3'h0 : last_ch;
          cnt_q   <= 7'h00;
          state_q <= halt_q ? ST_WAKE : ST_CONV;
          wake_q  <= 12'h000;
        end
        ST_WAKE: begin
          // start-up delay after halt release
          wake_q <= wake_q + 12'h001;
          if (wake_done) begin
            state_q <= ST_CONV;
          end
        end
        ST_CONV: begin
          if (tick) begin
            cnt_q <= cnt_q + 7'h01;
          end
          if (conv_end) begin
            state_q <= ST_NEXT;
          end
        end
        ST_NEXT: begin
          cnt_q <= 7'h00;
          if (!seq_last) begin
            chan_q  <= chan_q + 3'h1;
            state_q <= ST_CONV;
          end else if (repeat_) begin
            chan_q  <= scan ? 3'h0 : last_ch;
            state_q <= ST_CONV;
          end else begin
            state_q <= ST_IDLE; // run is still set here, so idle starts again
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // results
  always_ff @(posedge I_CLK_SYS) begin
    if (!I_RESET_N) begin
      for (int i = 0; i < 8; i++) begin
        result_q[i] <= 8'h00;
      end
    end else if (conv_end) begin
      result_q[chan_q] <= sample;
    end
  end

  // end of conversion interrupt request, one cycle
  always_ff @(posedge I_CLK_SYS) begin
    if (!I_RESET_N) begin
      eoc_q <= 1'b0;
    end else begin
      eoc_q <= done_pulse;
    end
  end

  // master cycles spent in the current conversion, for the length check
  always_ff @(posedge I_CLK_SYS) begin
    if (!I_RESET_N || state_q != ST_CONV) begin
      conv_cyc_q <= 8'h00;
    end else begin
      conv_cyc_q <= conv_cyc_q + 8'h01;
    end
  end

  // read ports
  always_ff @(posedge I_CLK_SYS) begin
    if (!I_RESET_N) begin
      rdata_q     <= 8'h00;
      res_rdata_q <= 8'h00;
    end else begin
      rdata_q <= (I_CFG_ADDR == `ADC_CTRL_ADDR) ? ctrl_q : 8'h00;
      if (res_hit(I_RES_ADDR)) begin
        res_rdata_q <= result_q[3'(I_RES_ADDR - `ADC_RESULT_BASE_ADDR)];
      end else begin
        res_rdata_q <= 8'h00;
      end
    end
  end

  assign O_CFG_RDATA = rdata_q;
  assign O_RES_RDATA = res_rdata_q;
  assign O_MUX_SEL   = chan_q;
  assign O_SAMPLE    = (state_q == ST_CONV);
  assign O_BIAS_EN   = active;
  assign O_EOC_IRQ   = eoc_q;

  sequence conv_done_s;
    conv_end ##1 (state_q == ST_NEXT);
  endsequence

  sequence start_s;
    (state_q == ST_IDLE) && active && run;
  endsequence

  eoc_single_a: assert property (@(posedge I_CLK_SYS) disable iff (!I_RESET_N)
    done_pulse |=> O_EOC_IRQ)
    else $error("eoc missing");
  run_clear_a: assert property (@(posedge I_CLK_SYS) disable iff (!I_RESET_N)
    (done_pulse && !repeat_ && !ctrl_wr) |=> !ctrl_q[0])
    else $error("run not cleared");
  repeat_keep_a: assert property (@(posedge I_CLK_SYS) disable iff (!I_RESET_N)
    (done_pulse && repeat_ && !ctrl_wr && !I_HALT) |=> ctrl_q[0])
    else $error("run dropped in repeat");
  halt_power_a: assert property (@(posedge I_CLK_SYS) disable iff (!I_RESET_N)
    I_HALT |=> !ctrl_q[2])
    else $error("power not forced off");
  halt_idle_a: assert property (@(posedge I_CLK_SYS) disable iff (!I_RESET_N)
    I_HALT |=> (state_q == ST_IDLE))
    else $error("converter active in halt");
  result_store_a: assert property (@(posedge I_CLK_SYS) disable iff (!I_RESET_N)
    conv_end |=> (result_q[$past(chan_q)] == $past(sample)))
    else $error("result not stored");
  scan_step_a: assert property (@(posedge I_CLK_SYS) disable iff (!I_RESET_N)
    (conv_done_s ##0 (active && run && !seq_last)) |=> (chan_q == $past(chan_q) + 3'h1))
    else $error("channel not stepped");
  saturate_top_a: assert property (@(posedge I_CLK_SYS) disable iff (!I_RESET_N)
    I_ABOVE_TOP |-> (sample == 8'hFF))
    else $error("no saturation");
  // counted in master cycles, so a broken tick divider shows up here too
  conv_len_a: assert property (@(posedge I_CLK_SYS) disable iff (!I_RESET_N)
    conv_end |-> (conv_cyc_q == (halve ? 8'hA3 : 8'h51)))
    else $error("conversion length wrong");
  wait_ignored_a: assert property (@(posedge I_CLK_SYS) disable iff (!I_RESET_N)
    (I_WAIT && state_q == ST_CONV && active && run && !conv_end) |=> (state_q == ST_CONV))
    else $error("wait disturbed conversion");
  halt_wake_a: assert property (@(posedge I_CLK_SYS) disable iff (!I_RESET_N)
    (start_s ##0 halt_q) |=> (state_q == ST_WAKE))
    else $error("no wake delay after halt");
  wake_done_a: assert property (@(posedge I_CLK_SYS) disable iff (!I_RESET_N)
    (state_q == ST_CONV && $past(state_q) == ST_WAKE) |-> ($past(wake_q) == 12'(STARTUP_CYCLES - 1)))
    else $error("wake delay cut short");
  run_start_a: assert property (@(posedge I_CLK_SYS) disable iff (!I_RESET_N)
    (start_s ##0 !halt_q) |=> O_SAMPLE)
    else $error("start ignored");
  single_chan_a: assert property (@(posedge I_CLK_SYS) disable iff (!I_RESET_N)
    (start_s ##0 !scan) |=> (chan_q == $past(last_ch)))
    else $error("wrong single channel");
  scan_start_a: assert property (@(posedge I_CLK_SYS) disable iff (!I_RESET_N)
    (start_s ##0 scan) |=> (chan_q == 3'h0))
    else $error("scan not from channel 0");
  repeat_wrap_a: assert property (@(posedge I_CLK_SYS) disable iff (!I_RESET_N)
    (conv_done_s ##0 (active && run && seq_last && repeat_)) |=>
      (state_q == ST_CONV && chan_q == ($past(scan) ? 3'h0 : $past(last_ch))))
    else $error("repeat did not restart");
  single_stop_a: assert property (@(posedge I_CLK_SYS) disable iff (!I_RESET_N)
    (conv_done_s ##0 (seq_last && !repeat_)) |=> (state_q == ST_IDLE))
    else $error("single run did not stop");
  stop_abort_a: assert property (@(posedge I_CLK_SYS) disable iff (!I_RESET_N)
    !run |=> (state_q == ST_IDLE))
    else $error("conversion ran on after stop");
  halve_tick_a: assert property (@(posedge I_CLK_SYS) disable iff (!I_RESET_N)
    (tick && halve && $past(halve)) |-> !$past(tick))
    else $error("halved clock ticks twice");
  eoc_once_a: assert property (@(posedge I_CLK_SYS) disable iff (!I_RESET_N)
    O_EOC_IRQ |=> !O_EOC_IRQ)
    else $error("eoc longer than one cycle");
  power_off_a: assert property (@(posedge I_CLK_SYS) disable iff (!I_RESET_N)
    !power |=> !O_SAMPLE)
    else $error("converting while powered down");
  cfg_read_a: assert property (@(posedge I_CLK_SYS) disable iff (!I_RESET_N)
    (I_CFG_ADDR == `ADC_CTRL_ADDR) |=> (O_CFG_RDATA == $past(ctrl_q)))
    else $error("control read back wrong");
  res_first_a: assert property (@(posedge I_CLK_SYS) disable iff (!I_RESET_N)
    (I_RES_ADDR == 5'h01) |=> (O_RES_RDATA == $past(result_q[0])))
    else $error("channel 0 not at address 1");
  res_last_a: assert property (@(posedge I_CLK_SYS) disable iff (!I_RESET_N)
    (I_RES_ADDR == 5'h08) |=> (O_RES_RDATA == $past(result_q[7])))
    else $error("channel 7 not at address 8");
  bottom_clamp_a: assert property (@(posedge I_CLK_SYS) disable iff (!I_RESET_N)
    (conv_end && I_BELOW_BOTTOM && !I_ABOVE_TOP) |=> (result_q[$past(chan_q)] == 8'h00))
    else $error("no clamp at bottom");

  // a result may only move when its own channel finishes
  generate
    for (genvar g = 0; g < 8; g++) begin : g_res_chk
      result_hold_a: assert property (@(posedge I_CLK_SYS) disable iff (!I_RESET_N)
        !(conv_end && (chan_q == 3'(g))) |=> $stable(result_q[g]))
        else $error("result changed without conversion");
    end
  endgenerate
endmodule : adc_scan_sequencer

//--- test_adc_scan_sequencer.sv
// self-checking bench for the converter scan sequencer
`include "adc_scan_consts.svh"
module test_adc_scan_sequencer;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int CONV = `ADC_CONV_CYCLES;
  logic       I_CLK_SYS      = 1'b0;
  logic       I_RESET_N      = 1'b0;
  logic       I_HALT         = 1'b0;
  logic       I_WAIT         = 1'b0;
  logic       I_CFG_WE       = 1'b0;
  logic [4:0] I_CFG_ADDR     = `ADC_CTRL_ADDR;
  logic [4:0] I_RES_ADDR     = `ADC_RESULT_BASE_ADDR;
  logic [7:0] I_CFG_WDATA    = 8'h00;
  logic [7:0] I_SAR_CODE     = 8'h00;
  logic       I_ABOVE_TOP    = 1'b0;
  logic       I_BELOW_BOTTOM = 1'b0;
  logic [7:0] O_CFG_RDATA;
  logic [7:0] O_RES_RDATA;
  logic [2:0] O_MUX_SEL;
  logic       O_SAMPLE;
  logic       O_BIAS_EN;
  logic       O_EOC_IRQ;
  int         error_cnt = 0;
  int         cmp_count = 0;
  int         n;
  logic [7:0] v;

  // short wake delay keeps the halt case quick
  localparam int WAKE = 4;
  adc_scan_sequencer #(.STARTUP_CYCLES(WAKE)) i_dut (
    .I_CLK_SYS(I_CLK_SYS), .I_RESET_N(I_RESET_N), .I_HALT(I_HALT), .I_WAIT(I_WAIT),
    .I_CFG_WE(I_CFG_WE), .I_CFG_ADDR(I_CFG_ADDR), .I_CFG_WDATA(I_CFG_WDATA),
    .O_CFG_RDATA(O_CFG_RDATA), .I_RES_ADDR(I_RES_ADDR), .O_RES_RDATA(O_RES_RDATA),
    .I_SAR_CODE(I_SAR_CODE), .I_ABOVE_TOP(I_ABOVE_TOP), .I_BELOW_BOTTOM(I_BELOW_BOTTOM),
    .O_MUX_SEL(O_MUX_SEL), .O_SAMPLE(O_SAMPLE), .O_BIAS_EN(O_BIAS_EN), .O_EOC_IRQ(O_EOC_IRQ)
  );

  always #12.5 I_CLK_SYS = ~I_CLK_SYS;

  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] s);
    cmp_count++;
    if (s !== e) begin
      $display("FAIL %s expected %h seen %h", nm, e, s);
      error_cnt++;
    end
  endtask : chk

  task automatic wr(input logic [7:0] d);
    I_CFG_ADDR  = `ADC_CTRL_ADDR;
    I_CFG_WDATA = d;
    I_CFG_WE    = 1'b1;
    @(negedge I_CLK_SYS);
    I_CFG_WE    = 1'b0;
  endtask : wr

  task automatic rd_cfg(input logic [4:0] a, output logic [7:0] d);
    I_CFG_ADDR = a;
    @(negedge I_CLK_SYS);
    d = O_CFG_RDATA;
  endtask : rd_cfg

  task automatic rd_res(input logic [4:0] a, output logic [7:0] d);
    I_RES_ADDR = a;
    @(negedge I_CLK_SYS);
    d = O_RES_RDATA;
  endtask : rd_res

  // k reaches lim when no pulse came; one extra edge lets the pulse drop
  task automatic wait_eoc(input int lim, output int k);
    k = 0;
    while (O_EOC_IRQ !== 1'b1 && k < lim) begin
      @(negedge I_CLK_SYS);
      k++;
    end
    @(negedge I_CLK_SYS);
  endtask : wait_eoc

  task automatic close_out;
    $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : close_out

  initial begin
    #(25 * 20000);
    error_cnt++;
    close_out();
  end

  initial begin
    repeat (4) @(negedge I_CLK_SYS);
    I_RESET_N = 1'b1;
    rd_cfg(5'h03, v); chk("ctrl_reset", 8'h00, v);
    rd_res(5'h01, v); chk("result_reset", 8'h00, v);
    chk("bias_reset", 8'h00, {7'h00, O_BIAS_EN});
    $display("test reset done");
    wr(8'h64);
    repeat (`ADC_STARTUP_CYCLES) @(negedge I_CLK_SYS);
    chk("bias_on", 8'h01, {7'h00, O_BIAS_EN});
    chk("idle_powered", 8'h00, {7'h00, O_SAMPLE});
    I_SAR_CODE = 8'h5A;
    wr(8'h65);
    @(negedge I_CLK_SYS);
    chk("mux_sel", 8'h03, {5'h00, O_MUX_SEL});
    chk("sampling", 8'h01, {7'h00, O_SAMPLE});
    wait_eoc(300, n);
    chk("conv_time", 8'h01, {7'h00, n >= CONV - 2 && n <= CONV + 3});
    rd_res(5'h04, v); chk("result_ch3", 8'h5A, v);
    rd_cfg(5'h03, v); chk("run_cleared", 8'h64, v);
    rd_res(5'h00, v); chk("unmapped_res", 8'h00, v);
    rd_cfg(5'h04, v); chk("unmapped_cfg", 8'h00, v);
    $display("test single channel done");
    I_ABOVE_TOP = 1'b1;
    wr(8'h05);
    wait_eoc(300, n);
    rd_res(5'h01, v); chk("saturate_top", 8'hFF, v);
    I_ABOVE_TOP    = 1'b0;
    I_BELOW_BOTTOM = 1'b1;
    wr(8'h05);
    wait_eoc(300, n);
    rd_res(5'h01, v); chk("clamp_bottom", 8'h00, v);
    I_BELOW_BOTTOM = 1'b0;
    $display("test range done");
    I_SAR_CODE = 8'h3C;
    wr(8'h5D);
    wait_eoc(900, n);
    chk("scan_halved_time", 8'h01, {7'h00, n == 3 * (2 * CONV + 1)});
    for (int a = 1; a <= 3; a++) begin
      rd_res(a[4:0], v); chk("scan_result", 8'h3C, v);
    end
    rd_res(5'h04, v); chk("beyond_last", 8'h5A, v);
    rd_cfg(5'h03, v); chk("scan_run_clr", 8'h5C, v);
    wait_eoc(200, n); chk("one_eoc_only", 8'h01, {7'h00, n == 200});
    I_SAR_CODE = 8'h11;
    wr(8'h0D);
    wait_eoc(300, n);
    rd_res(5'h01, v); chk("last_zero_ch0", 8'h11, v);
    rd_res(5'h02, v); chk("last_zero_ch1", 8'h3C, v);
    $display("test scan single done");
    I_WAIT     = 1'b1;
    I_SAR_CODE = 8'h21;
    wr(8'h27);
    wait_eoc(300, n);
    rd_res(5'h02, v); chk("repeat_first", 8'h21, v);
    I_SAR_CODE = 8'h22;
    wait_eoc(300, n); chk("repeat_eoc", 8'h01, {7'h00, n < 300});
    rd_res(5'h02, v); chk("repeat_overwrite", 8'h22, v);
    rd_cfg(5'h03, v); chk("repeat_run_kept", 8'h27, v);
    wr(8'h26);
    wait_eoc(200, n); chk("repeat_stopped", 8'h01, {7'h00, n == 200});
    I_WAIT     = 1'b0;
    I_SAR_CODE = 8'h44;
    wr(8'h2F);
    wait_eoc(400, n);
    I_SAR_CODE = 8'h55;
    wait_eoc(400, n);
    rd_res(5'h01, v); chk("cyclic_ch0", 8'h55, v);
    rd_res(5'h02, v); chk("cyclic_ch1", 8'h55, v);
    wr(8'h2E);
    wait_eoc(200, n); chk("cyclic_stopped", 8'h01, {7'h00, n == 200});
    $display("test continuous done");
    wr(8'h01);
    wait_eoc(200, n); chk("run_unpowered", 8'h01, {7'h00, n == 200});
    wr(8'h05);
    repeat (10) @(negedge I_CLK_SYS);
    I_HALT = 1'b1;
    @(negedge I_CLK_SYS);
    chk("bias_in_halt", 8'h00, {7'h00, O_BIAS_EN});
    wait_eoc(200, n); chk("halt_aborts", 8'h01, {7'h00, n == 200});
    I_HALT = 1'b0;
    rd_cfg(5'h03, v); chk("halt_pow_clr", 8'h01, v);
    wr(8'h04);
    repeat (`ADC_STARTUP_CYCLES) @(negedge I_CLK_SYS);
    I_SAR_CODE = 8'h66;
    wr(8'h05);
    wait_eoc(300, n); chk("wake_delay", 8'h01, {7'h00, n == CONV + WAKE + 1});
    rd_res(5'h01, v); chk("after_halt", 8'h66, v);
    $display("test power and halt done");
    close_out();
  end
endmodule : test_adc_scan_sequencer
